// ==== hdl/mrsp_pkg.sv ====
package mrsp_pkg;
  // Two-wire address of this monitor; the value is arbitrary.
  localparam logic [6:0]  SLAVE_ADDR      = 7'h4a;

  // Conversion result layout in a stream word: voltage high, current low.
  localparam int          CODE_W          = 12;
  localparam int          WORD_W          = 2 * CODE_W;
  localparam int          FIFO_DEPTH      = 32;
  localparam int          ADC_CODES       = 4096;

  // Full scale of the voltage channel in millivolts, per divider choice.
  localparam int          V_FS_NARROW_MV  = 6650;
  localparam int          V_FS_WIDE_MV    = 26350;
  // Full scale of the current channel in units of 10 microvolts.
  localparam int          I_FS_10UV       = 10584;

  // Conversion modes.
  localparam logic [1:0]  MODE_BOTH       = 2'h0;
  localparam logic [1:0]  MODE_VOLT       = 2'h1;
  localparam logic [1:0]  MODE_CURR       = 2'h2;

  // Status byte field positions.
  localparam int          ST_CONV_OC      = 0;
  localparam int          ST_ADC_ALERT    = 1;
  localparam int          ST_SW_OC        = 2;
  localparam int          ST_SW_FAIL      = 3;
  localparam int          ST_OFF          = 4;
  localparam int          ST_OFF_ALERT    = 5;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;

  // Synchroniser slots for pin inputs.
  localparam int          SY_SCL          = 0;
  localparam int          SY_SDA          = 1;
  localparam int          SY_PWR_EN       = 2;
  localparam int          SY_SW_OC        = 3;
  localparam int          SY_SW_FAIL      = 4;
  localparam int          SY_N            = 5;

  // Bits per byte, less one, and history depth of current comparisons.
  localparam logic [3:0]  LAST_BIT        = 4'h7;
  localparam int          OC_HIST         = 4;
endpackage : mrsp_pkg

// ==== hdl/mrsp_readback.sv ====
// What this block does
// - Master starts, sends 7-bit address with read bit; the addressed device acknowledges.
// - Voltage-only or current-only mode reads just two bytes.
// - Voltage code is supply times 4096 over 6.65 V or 26.35 V full scale.
// - Current code is sense voltage times 4096 over 105.84 mV full scale.
// - Status mode returns one status byte after the address acknowledge.
// - Status bit 0 is live: last three current conversions exceeded the threshold.
// - Status bit 1 latches on a conversion overcurrent alert until cleared.
// - Status bit 2 shows switch off by analog overcurrent, per variant.
// - Status bit 3 latches on hot swap failure until cleared.
// - Status bit 4 reads one while enable pin is low or forced off.
// - Status bit 5 latches on an alert from enable pin or forced-off bit.
// - Sticky bits 1, 3 and 5 clear only via the clear bit write.
// - With status select set, reads return the status byte, not data.
// - Combined order: voltage high byte, current high byte, then both low nibbles.
// - Clear bit self-returns to zero; present enabled causes may set again.
`timescale 1ns/1ps

module mrsp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;
  logic [AW:0]      cnt_d;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
    if (!rst_n) begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q     <= cnt_d;
      // Flags are registered so both ports come straight from flops.
      in_ready  <= (cnt_d != (AW+1)'(DEPTH));
      out_valid <= (cnt_d != '0);
    end
  end
endmodule : mrsp_fifo

module mrsp_readback
  import mrsp_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Two-wire pins
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  // Conversion results from the converter
  input  wire logic                   conv_valid,
  output logic                        conv_ready,
  input  wire logic [mrsp_pkg::CODE_W-1:0] conv_volt_code,
  input  wire logic [mrsp_pkg::CODE_W-1:0] conv_curr_code,
  // Configuration held by the command and extended registers
  input  wire logic [1:0]             conv_mode,
  input  wire logic                   status_select,
  input  wire logic                   voltage_divider_select,
  input  wire logic [7:0]             alert_threshold,
  input  wire logic                   adc_alert_single_enable,
  input  wire logic                   adc_alert_quad_enable,
  input  wire logic                   switch_failure_alert_enable,
  input  wire logic                   off_alert_enable,
  input  wire logic                   clear_write,
  input  wire logic                   forced_off_bit,
  input  wire logic                   latch_off_variant,
  // Hot swap condition pins
  input  wire logic                   power_enable_pin,
  input  wire logic                   switch_off_overcurrent,
  input  wire logic                   hot_swap_fail,
  // Status and control outputs
  output logic [7:0]                  alert_status_byte,
  output logic                        clear_bit,
  output logic                        divider_select_out
);
  import mrsp_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_ADDR   = 6'b000010,
    ST_AACK   = 6'b000100,
    ST_TX     = 6'b001000,
    ST_MACK   = 6'b010000,
    ST_WAIT   = 6'b100000
  } mrsp_fsm_e;

  typedef struct packed {
    logic [SY_N-1:0]    sync1;
    logic [SY_N-1:0]    sync2;
    logic               scl_prev;
    logic               sda_prev;
    logic               fail_prev;
    logic               off_prev;
    mrsp_fsm_e          state;
    logic [7:0]         shreg;
    logic [3:0]         bitcnt;
    logic [1:0]         byte_idx;
    logic [1:0]         nbytes;
    logic               mst_ack;
    logic [WORD_W-1:0]  snap;
    logic [7:0]         stat_snap;
    logic               stat_mode;
    logic [1:0]         mode_snap;
    logic [OC_HIST-1:0] oc_hist;
    logic               clear_pend;
    logic [7:0]         status;
    logic               sda_oe;
    logic               sda_out;
    logic               div_sel;
  } mrsp_state_s;

  mrsp_state_s         r_q;
  mrsp_state_s         r_d;
  logic                fifo_valid;
  logic [WORD_W-1:0]   fifo_data;
  logic                fifo_pop;
  logic                conv_take;
  logic                scl_s;
  logic                sda_s;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_seen;
  logic                stop_seen;
  logic                addr_hit;

  assign scl_s      = r_q.sync2[SY_SCL];
  assign sda_s      = r_q.sync2[SY_SDA];
  assign scl_rise   = scl_s && !r_q.scl_prev;
  assign scl_fall   = !scl_s && r_q.scl_prev;
  assign start_seen = scl_s && r_q.scl_prev && r_q.sda_prev && !sda_s;
  assign stop_seen  = scl_s && r_q.scl_prev && !r_q.sda_prev && sda_s;
  // Address byte complete, our address, direction bit high.
  assign addr_hit   = (r_q.state == ST_ADDR) && scl_fall && (r_q.bitcnt == 4'h8)
                      && (r_q.shreg[7:1] == SLAVE_ADDR) && r_q.shreg[0];
  assign fifo_pop   = addr_hit && fifo_valid;
  assign conv_take  = conv_valid && conv_ready;

  // Conversions queue here so a slow reader stalls the converter instead of
  // losing results; a reader that falls behind therefore sees older samples.
  mrsp_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (conv_valid),
    .in_ready  (conv_ready),
    .in_data   ({conv_volt_code, conv_curr_code}),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  function automatic logic [7:0] pick_byte(input logic [WORD_W-1:0] w,
                                           input logic [1:0]        mode,
                                           input logic [1:0]        idx);
    logic [CODE_W-1:0] v;
    logic [CODE_W-1:0] c;
    v = w[WORD_W-1:CODE_W];
    c = w[CODE_W-1:0];
    pick_byte = 8'h00;
    case (mode)
      MODE_VOLT: pick_byte = (idx == 2'h0) ? v[11:4] : {v[3:0], 4'h0};
      MODE_CURR: pick_byte = (idx == 2'h0) ? c[11:4] : {c[3:0], 4'h0};
      default: begin
        if (idx == 2'h0) begin
          pick_byte = v[11:4];
        end else if (idx == 2'h1) begin
          pick_byte = c[11:4];
        end else begin
          pick_byte = {v[3:0], c[3:0]};
        end
      end
    endcase
  endfunction : pick_byte

  always_comb begin
    logic [7:0] nxt;
    logic       sw_fail_now;
    logic       off_now;
    logic       adc_trip;
    logic [OC_HIST-1:0] hist;
    nxt         = 8'h00;
    sw_fail_now = 1'b0;
    off_now     = 1'b0;
    adc_trip    = 1'b0;
    hist        = '0;
    r_d         = r_q;
    r_d.sync1   = {hot_swap_fail, switch_off_overcurrent, power_enable_pin, sda_in, scl_in};
    r_d.sync2   = r_q.sync1;
    r_d.scl_prev = scl_s;
    r_d.sda_prev = sda_s;
    // The converter already scales codes through the selected divider.
    r_d.div_sel = voltage_divider_select;

    // Serial engine.
    case (r_q.state)
      ST_IDLE: begin
        r_d.sda_oe = 1'b0;
      end
      ST_ADDR: begin
        if (scl_rise) begin
          r_d.shreg  = {r_q.shreg[6:0], sda_s};
          r_d.bitcnt = r_q.bitcnt + 4'h1;
        end else if (scl_fall && r_q.bitcnt == 4'h8) begin
          if (addr_hit) begin
            r_d.state  = ST_AACK;
            r_d.sda_oe = 1'b1;
            // Freeze everything the read will return.
            if (fifo_valid) begin
              r_d.snap = fifo_data;
            end
            r_d.stat_snap = r_q.status;
            r_d.stat_mode = status_select;
            r_d.mode_snap = conv_mode;
            if (status_select) begin
              r_d.nbytes = 2'h1;
            end else if (conv_mode == MODE_VOLT || conv_mode == MODE_CURR) begin
              r_d.nbytes = 2'h2;
            end else begin
              r_d.nbytes = 2'h3;
            end
          end else begin
            r_d.state = ST_WAIT;
          end
        end
      end
      ST_AACK: begin
        if (scl_fall) begin
          nxt          = r_q.stat_mode ? r_q.stat_snap
                                       : pick_byte(r_q.snap, r_q.mode_snap, 2'h0);
          r_d.state    = ST_TX;
          r_d.shreg    = nxt;
          r_d.byte_idx = 2'h0;
          r_d.bitcnt   = 4'h0;
          r_d.sda_oe   = !nxt[7];
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          if (r_q.bitcnt == LAST_BIT) begin
            r_d.state  = ST_MACK;
            r_d.sda_oe = 1'b0;
          end else begin
            r_d.shreg  = {r_q.shreg[6:0], 1'b0};
            r_d.bitcnt = r_q.bitcnt + 4'h1;
            r_d.sda_oe = !r_q.shreg[6];
          end
        end
      end
      ST_MACK: begin
        if (scl_rise) begin
          r_d.mst_ack = !sda_s;
        end else if (scl_fall) begin
          if (r_q.mst_ack && (r_q.byte_idx + 2'h1) < r_q.nbytes) begin
            nxt          = pick_byte(r_q.snap, r_q.mode_snap, r_q.byte_idx + 2'h1);
            r_d.state    = ST_TX;
            r_d.shreg    = nxt;
            r_d.byte_idx = r_q.byte_idx + 2'h1;
            r_d.bitcnt   = 4'h0;
            r_d.sda_oe   = !nxt[7];
          end else begin
            // A not-acknowledge or a surplus acknowledge ends our part.
            r_d.state  = ST_WAIT;
            r_d.sda_oe = 1'b0;
          end
        end
      end
      ST_WAIT: begin
        r_d.sda_oe = 1'b0;
      end
      default: begin
        r_d.state  = ST_IDLE;
        r_d.sda_oe = 1'b0;
      end
    endcase
    if (start_seen) begin
      r_d.state  = ST_ADDR;
      r_d.bitcnt = 4'h0;
      r_d.sda_oe = 1'b0;
    end else if (stop_seen) begin
      r_d.state  = ST_IDLE;
      r_d.sda_oe = 1'b0;
    end

    // Current comparison history, one entry per accepted conversion.
    hist = r_q.oc_hist;
    if (conv_take) begin
      hist = {r_q.oc_hist[OC_HIST-2:0], (conv_curr_code[11:4] > alert_threshold)};
    end
    r_d.oc_hist = hist;
    adc_trip = conv_take && ((adc_alert_single_enable && hist[0])
                             || (adc_alert_quad_enable && (&hist)));

    sw_fail_now   = r_q.sync2[SY_SW_FAIL];
    off_now       = !r_q.sync2[SY_PWR_EN] || forced_off_bit;
    r_d.fail_prev = sw_fail_now;
    r_d.off_prev  = off_now;

    // Clearing sticky bits; a fresh event in the same cycle still sets.
    if (clear_write) begin
      r_d.clear_pend = 1'b1;
    end
    if (r_q.clear_pend) begin
      r_d.status[ST_ADC_ALERT] = 1'b0;
      r_d.status[ST_SW_FAIL]   = 1'b0;
      r_d.status[ST_OFF_ALERT] = 1'b0;
      r_d.clear_pend           = clear_write;
    end
    if (adc_trip) begin
      r_d.status[ST_ADC_ALERT] = 1'b1;
    end
    // A still-present enabled cause sets again right after a clear.
    if (sw_fail_now && switch_failure_alert_enable
        && (!r_q.fail_prev || r_q.clear_pend)) begin
      r_d.status[ST_SW_FAIL] = 1'b1;
    end
    if (off_now && off_alert_enable && (!r_q.off_prev || r_q.clear_pend)) begin
      r_d.status[ST_OFF_ALERT] = 1'b1;
    end
    r_d.status[ST_CONV_OC] = &hist[2:0];
    r_d.status[ST_SW_OC]   = latch_off_variant
                             ? (switch_failure_alert_enable && r_d.status[ST_SW_FAIL])
                             : r_q.sync2[SY_SW_OC];
    r_d.status[ST_OFF]     = off_now;
    r_d.status[7:6]        = 2'h0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_q           <= '0;
      r_q.sync1     <= {SY_N{1'b1}};
      r_q.sync2     <= {SY_N{1'b1}};
      r_q.scl_prev  <= 1'b1;
      r_q.sda_prev  <= 1'b1;
      r_q.state     <= ST_IDLE;
      r_q.status    <= STATUS_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  assign sda_out            = r_q.sda_out;
  assign sda_oe             = r_q.sda_oe;
  assign alert_status_byte  = r_q.status;
  assign clear_bit          = r_q.clear_pend;
  assign divider_select_out = r_q.div_sel;
endmodule : mrsp_readback

// ==== bench/mrsp_readback_properties.sv ====
`timescale 1ns/1ps
module mrsp_readback_properties (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Two-wire pins
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Status causes and controls
  input wire logic       clear_write,
  input wire logic       clear_bit,
  input wire logic       forced_off_bit,
  input wire logic       power_enable_pin,
  input wire logic       adc_alert_single_enable,
  input wire logic       adc_alert_quad_enable,
  input wire logic       switch_failure_alert_enable,
  input wire logic       off_alert_enable,
  input wire logic [7:0] alert_status_byte
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // With every alert disabled nothing may re-set a sticky bit behind a clear.
  logic quiet;
  assign quiet = !(adc_alert_single_enable || adc_alert_quad_enable ||
                   switch_failure_alert_enable || off_alert_enable);

  sequence stop_s;
    scl_in && !sda_in ##1 scl_in && sda_in;
  endsequence
  sequence pin_low_s;
    !power_enable_pin [*3];
  endsequence

  sda_open_a: assert property (sda_out == 1'b0) else $error("data pin driven high");
  sda_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved while bus clock high");
  stop_release_a: assert property (stop_s |=> !sda_oe [*4])
    else $error("data line held after stop");
  clear_set_a: assert property (clear_write |=> clear_bit) else $error("clear bit not set");
  clear_self_a: assert property (clear_bit |=> !clear_bit)
    else $error("clear bit did not return to zero");
  sticky_hold_a: assert property (!clear_bit |=>
    ((~alert_status_byte & $past(alert_status_byte)) & 8'h2a) == 8'h00)
    else $error("sticky bit dropped without clear");
  clear_wipe_a: assert property (clear_bit && quiet |=>
    (alert_status_byte & 8'h2a) == 8'h00) else $error("sticky bits survived clear");
  forced_off_a: assert property (forced_off_bit |=> alert_status_byte[4])
    else $error("forced off not shown");
  pin_off_a: assert property (pin_low_s |=> alert_status_byte[4])
    else $error("enable pin low not shown");
  status_top_a: assert property (alert_status_byte[7:6] == 2'h0)
    else $error("unused status bits set");
endmodule : mrsp_readback_properties

bind mrsp_readback mrsp_readback_properties i_props (
  .clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe, .clear_write, .clear_bit,
  .forced_off_bit, .power_enable_pin, .adc_alert_single_enable, .adc_alert_quad_enable,
  .switch_failure_alert_enable, .off_alert_enable, .alert_status_byte);

// ==== bench/mrsp_master_model.sv ====
`timescale 1ns/1ps
module mrsp_master_model #(
  parameter int HALF = 6
) (
  // Clock
  input wire logic clk,
  // Bus
  input wire logic sda_oe,
  output logic     scl,
  output logic     sda
);
  logic m_low;

  // The line has a pull-up, so a released line reads high.
  assign sda = !(m_low || sda_oe);
  initial begin
    scl = 1'b1;
    m_low = 1'b0;
  end

  task automatic wait_h;
    repeat (HALF) @(negedge clk);
  endtask : wait_h

  // Data moves one cycle after the clock fall, well clear of the high phase.
  task automatic put_bit(input logic b, output logic s);
    @(negedge clk);
    m_low = !b;
    wait_h();
    scl = 1'b1;
    wait_h();
    s = sda;
    scl = 1'b0;
  endtask : put_bit

  task automatic xfer(input logic [7:0] ab, input int n, input bit ack_last,
                      output logic ack, output logic [23:0] d);
    logic s;
    d = '0;
    @(negedge clk);
    m_low = 1'b1;
    wait_h();
    scl = 1'b0;
    for (int i = 7; i >= 0; i--) put_bit(ab[i], s);
    put_bit(1'b1, s);
    ack = !s;
    for (int b = 0; b < n && ack; b++) begin
      for (int i = 0; i < 8; i++) begin
        put_bit(1'b1, s);
        d = {d[22:0], s};
      end
      put_bit(!(b < n - 1 || ack_last), s);
    end
    @(negedge clk);
    m_low = 1'b1;
    wait_h();
    scl = 1'b1;
    wait_h();
    m_low = 1'b0;
    wait_h();
  endtask : xfer
endmodule : mrsp_master_model

// ==== bench/monitor_readback_status_port_test.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module monitor_readback_status_port_test;
  import mrsp_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, scl_in, sda_in, sda_out, sda_oe;
  logic        conv_valid = 1'b0, conv_ready, status_select = 1'b0;
  logic [11:0] conv_volt_code = 12'h000, conv_curr_code = 12'h000;
  logic [1:0]  conv_mode = 2'h0;
  logic [7:0]  alert_threshold = 8'hff, alert_status_byte;
  logic        voltage_divider_select = 1'b0, adc_alert_single_enable = 1'b0;
  logic        adc_alert_quad_enable = 1'b0, switch_failure_alert_enable = 1'b0;
  logic        off_alert_enable = 1'b0, clear_write = 1'b0, forced_off_bit = 1'b0;
  logic        latch_off_variant = 1'b0, power_enable_pin = 1'b1;
  logic        switch_off_overcurrent = 1'b0, hot_swap_fail = 1'b0;
  logic        clear_bit, divider_select_out, ack, took;
  logic [23:0] last_w = 24'h000000, got;
  int          err_total = 0, compares = 0, n;
  logic [23:0] q[$];

  mrsp_readback i_dut (.clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe, .conv_valid,
    .conv_ready, .conv_volt_code, .conv_curr_code, .conv_mode, .status_select,
    .voltage_divider_select, .alert_threshold, .adc_alert_single_enable,
    .adc_alert_quad_enable, .switch_failure_alert_enable, .off_alert_enable, .clear_write,
    .forced_off_bit, .latch_off_variant, .power_enable_pin, .switch_off_overcurrent,
    .hot_swap_fail, .alert_status_byte, .clear_bit, .divider_select_out);
  mrsp_master_model i_master (.clk, .sda_oe, .scl(scl_in), .sda(sda_in));

  always #20 clk = ~clk;

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // Valid stays high between pushes; callers lower it after the last one.
  task automatic push(input logic [23:0] w);
    conv_volt_code = w[23:12];
    conv_curr_code = w[11:0];
    conv_valid = 1'b1;
    took = conv_ready;
    @(negedge clk);
    if (took) q.push_back(w);
  endtask : push

  task automatic rd(input logic [1:0] m, input bit st, input logic [7:0] est);
    logic [23:0] e;
    conv_mode = m;
    status_select = st;
    // Every read of our address takes the oldest queued word, status reads too.
    if (q.size() > 0) last_w = q.pop_front();
    case (m)
      MODE_BOTH: e = {last_w[23:16], last_w[11:4], last_w[15:12], last_w[3:0]};
      MODE_VOLT: e = {8'h00, last_w[23:16], last_w[15:12], 4'h0};
      default:   e = {8'h00, last_w[11:4], last_w[3:0], 4'h0};
    endcase
    if (st) e = {16'h0000, est};
    i_master.xfer({SLAVE_ADDR, 1'b1}, st ? 1 : (m == MODE_BOTH ? 3 : 2), st, ack, got);
    `CHK("addr ack", 1'b1, ack)
    `CHK("read data", e, got)
  endtask : rd

  task automatic st_chk(input logic [7:0] e);
    repeat (5) @(negedge clk);
    `CHK("status", e, alert_status_byte)
  endtask : st_chk

  initial begin
    repeat (50000) @(posedge clk);
    $display("timeout reached");
    err_total++;
    final_report();
  end

  initial begin
    void'($urandom(30969));
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    n = 0;
    for (int k = 0; k < 40; k++) begin
      push(24'($urandom));
      n += int'(took);
    end
    conv_valid = 1'b0;
    `CHK("fifo words", 32, n)
    `CHK("ready when full", 1'b0, conv_ready)
    $display("test fill done");
    i_master.xfer({~SLAVE_ADDR, 1'b1}, 1, 1'b0, ack, got);
    `CHK("foreign addr", 1'b0, ack)
    for (int k = 0; k < 33; k++) rd(2'(k % 3), 1'b0, 8'h00);
    // A word landing mid-read must not disturb the bytes already frozen.
    fork
      rd(MODE_BOTH, 1'b0, 8'h00);
      begin
        repeat (150) @(negedge clk);
        // Codes for a 3.3 V supply on the narrow range and a 50 mV sense drop.
        push({12'(3300 * ADC_CODES / V_FS_NARROW_MV), 12'(5000 * ADC_CODES / I_FS_10UV)});
        conv_valid = 1'b0;
      end
    join
    rd(MODE_BOTH, 1'b0, 8'h00);
    $display("test readback done");
    alert_threshold = 8'h80;
    adc_alert_single_enable = 1'b1;
    for (int k = 0; k < 3; k++) push(24'h000ff0);
    conv_valid = 1'b0;
    st_chk(8'h03);
    push(24'h000100);
    conv_valid = 1'b0;
    st_chk(8'h02);
    forced_off_bit = 1'b1;
    off_alert_enable = 1'b1;
    st_chk(8'h32);
    forced_off_bit = 1'b0;
    st_chk(8'h22);
    power_enable_pin = 1'b0;
    st_chk(8'h32);
    power_enable_pin = 1'b1;
    switch_failure_alert_enable = 1'b1;
    latch_off_variant = 1'b1;
    hot_swap_fail = 1'b1;
    st_chk(8'h2e);
    hot_swap_fail = 1'b0;
    rd(MODE_BOTH, 1'b1, 8'h2e);
    {adc_alert_single_enable, off_alert_enable, switch_failure_alert_enable} = 3'h0;
    clear_write = 1'b1;
    @(negedge clk);
    clear_write = 1'b0;
    `CHK("clear bit", 1'b1, clear_bit)
    st_chk(8'h00);
    `CHK("clear bit", 1'b0, clear_bit)
    latch_off_variant = 1'b0;
    switch_off_overcurrent = 1'b1;
    st_chk(8'h04);
    switch_off_overcurrent = 1'b0;
    st_chk(8'h00);
    // Four in a row above the threshold are needed once only the quad alert is on.
    adc_alert_quad_enable = 1'b1;
    for (int k = 0; k < 3; k++) push(24'h000ff0);
    conv_valid = 1'b0;
    st_chk(8'h01);
    push(24'h000ff0);
    conv_valid = 1'b0;
    st_chk(8'h03);
    voltage_divider_select = 1'b1;
    @(negedge clk);
    `CHK("divider", 1'b1, divider_select_out)
    $display("test status done");
    final_report();
  end
endmodule : monitor_readback_status_port_test
